// *** core/sdid_pkg.sv ***
package sdid_pkg;

   // Core clock and the controller timing it is checked against
   localparam int CLK_PERIOD_NS = 100;
   localparam int DIR_SETUP_NS  = 5000;
   localparam int PULSE_MIN_NS  = 1200;
   // Least times round up to whole cycles
   localparam int DIR_SETUP_CYC =
      (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_MIN_CYC =
      (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 8;

   // Register map, byte addresses
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_POS    = 12'h008;
   localparam logic [11:0] ADDR_ERR    = 12'h00C;

   // Control register fields
   localparam int         CTRL_W          = 8;
   localparam int         CTRL_MODE_BIT   = 0;
   localparam int         CTRL_POL_BIT    = 1;
   localparam int         CTRL_STYLE_BIT  = 2;
   localparam int         CTRL_GATED_BIT  = 3;
   localparam int         CTRL_RES_LSB    = 4;
   localparam int         RES_W           = 4;
   localparam logic [7:0] CTRL_RESET      = 8'h00;

   // Status register fields
   localparam int STAT_EN_BIT    = 0;
   localparam int STAT_DIR_BIT   = 1;
   localparam int STAT_FB_BIT    = 2;
   localparam int STAT_DIV_LSB   = 8;

   // Sticky error register fields
   localparam int         ERR_W          = 2;
   localparam int         ERR_PULSE_BIT  = 0;
   localparam int         ERR_SETUP_BIT  = 1;
   localparam logic [1:0] ERR_RESET      = 2'h0;

   // Resolution divisors
   localparam int         DIV_W        = 9;
   localparam logic [8:0] DIV_BIN_BASE = 9'h002;
   localparam logic [8:0] DIV_DEC_0    = 9'h005;
   localparam logic [8:0] DIV_DEC_1    = 9'h00A;
   localparam logic [8:0] DIV_DEC_2    = 9'h019;
   localparam logic [8:0] DIV_DEC_3    = 9'h032;
   localparam logic [8:0] DIV_DEC_4    = 9'h07D;
   localparam logic [8:0] DIV_DEC_5    = 9'h0FA;
   localparam logic [8:0] DIV_FALLBACK = 9'h100;

endpackage

// *** core/sdid_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdid_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sdid_sync_s;

   sdid_sync_s st_r;
   sdid_sync_s st_nxt;

   if (W < 1) begin : g_bad_w
      $error("sdid_sync: width must be at least one");
   end

   // First stage feeds only the second stage
   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = i_async;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.sync;

endmodule
`default_nettype wire

// *** core/sdid_res_dec.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdid_res_dec
   import sdid_pkg::*;
(
   input  wire logic [RES_W-1:0] i_sw,
   output logic      [DIV_W-1:0] o_div,
   output logic                  o_fallback
);

   logic [2:0] code;

   always_comb begin
      code       = i_sw[3:1];
      o_fallback = 1'b0;
      o_div      = DIV_FALLBACK;
      if (!i_sw[0]) begin
         o_div = DIV_BIN_BASE << code;
      end else begin
         case (code)
            3'h0: o_div = DIV_DEC_0;
            3'h1: o_div = DIV_DEC_1;
            3'h2: o_div = DIV_DEC_2;
            3'h3: o_div = DIV_DEC_3;
            3'h4: o_div = DIV_DEC_4;
            3'h5: o_div = DIV_DEC_5;
            default: begin
               o_div      = DIV_FALLBACK;
               o_fallback = 1'b1;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** core/sdid_top.sv ***
// What this block does
// - Pulse/direction: one microstep per selected edge
// - Pulse/direction: direction input is a static level
// - Dual-pulse: step input gives forward pulses
// - Dual-pulse: direction input gives reverse pulses
// - Gate high enables for NPN, inverted otherwise
// - Unconnected gate leaves the drive enabled
// - Decode b5..b8 into step resolution
`timescale 1ns/10ps
`default_nettype none

module sdid_top
   import sdid_pkg::*;
#(
   parameter int POS_W = 32
) (
   input  wire logic              i_mclk,
   input  wire logic              i_srst,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   input  wire logic              i_step_pulse_input,
   input  wire logic              i_rotation_sense_input,
   input  wire logic              i_output_gate_input,
   output logic                   o_step_event,
   output logic                   o_step_dir,
   output logic                   o_drive_enable,
   output logic      [DIV_W-1:0]  o_res_div,
   output logic                   o_res_fallback
);

   if (POS_W < 2 || POS_W > 32) begin : g_bad_pos
      $error("sdid_top: position width must be 2 to 32");
   end

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [POS_W-1:0]  pos;
      logic [ERR_W-1:0]  err;
      logic              fwd_prev;
      logic              rev_prev;
      logic              dir_prev;
      logic [CNT_W-1:0]  dir_age;
      logic [CNT_W-1:0]  width;
      logic              step_ev;
      logic              step_dir;
      logic              drv_en;
      logic [DIV_W-1:0]  div;
      logic              fallback;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
   } sdid_state_s;

   sdid_state_s st_r;
   sdid_state_s st_nxt;

   logic [2:0]       pins_sync;
   logic             step_s;
   logic             dir_s;
   logic             gate_s;
   logic [DIV_W-1:0] dec_div;
   logic             dec_fallback;

   sdid_sync #(
      .W (3)
   ) u_sync (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_async ({i_output_gate_input, i_rotation_sense_input,
                 i_step_pulse_input}),
      .o_sync  (pins_sync)
   );

   assign step_s = pins_sync[0];
   assign dir_s  = pins_sync[1];
   assign gate_s = pins_sync[2];

   sdid_res_dec u_res_dec (
      .i_sw       (st_r.ctrl[CTRL_RES_LSB +: RES_W]),
      .o_div      (dec_div),
      .o_fallback (dec_fallback)
   );

   logic             mode_dual;
   logic             pol_low;
   logic             fwd_n;
   logic             rev_n;
   logic             fwd_rise;
   logic             rev_rise;
   logic             fwd_fall;
   logic             enabled;
   logic             ev;
   logic             ev_dir;
   logic [ERR_W-1:0] err_set;
   logic             setup;
   logic             commit_wr;
   logic             hit;
   logic [31:0]      rd_val;

   always_comb begin
      st_nxt    = st_r;
      mode_dual = st_r.ctrl[CTRL_MODE_BIT];
      pol_low   = st_r.ctrl[CTRL_POL_BIT];
      err_set   = '0;

      // Normalise so that the active edge or level is always a rise
      fwd_n    = step_s ^ pol_low;
      rev_n    = dir_s ^ pol_low;
      fwd_rise = fwd_n & ~st_r.fwd_prev;
      rev_rise = rev_n & ~st_r.rev_prev;
      fwd_fall = ~fwd_n & st_r.fwd_prev;
      st_nxt.fwd_prev = fwd_n;
      st_nxt.rev_prev = rev_n;
      st_nxt.dir_prev = dir_s;

      // Unconnected gate is modelled by the gated bit left clear
      if (!st_r.ctrl[CTRL_GATED_BIT]) begin
         enabled = 1'b1;
      end else begin
         enabled = gate_s ^ st_r.ctrl[CTRL_STYLE_BIT];
      end

      if (!mode_dual) begin
         ev     = fwd_rise;
         ev_dir = dir_s;
      end else begin
         // Coincident forward and reverse pulses cancel out
         ev     = fwd_rise ^ rev_rise;
         ev_dir = rev_rise;
      end
      // A disabled drive ignores step commands
      ev = ev & enabled;

      // Direction age since last level change, saturating
      if (dir_s != st_r.dir_prev) begin
         st_nxt.dir_age = '0;
      end else if (st_r.dir_age != {CNT_W{1'b1}}) begin
         st_nxt.dir_age = st_r.dir_age + 1'b1;
      end
      if (!mode_dual && fwd_rise &&
          st_r.dir_age < CNT_W'(DIR_SETUP_CYC)) begin
         err_set[ERR_SETUP_BIT] = 1'b1;
      end

      // Active width of the step input, saturating
      if (!fwd_n) begin
         st_nxt.width = '0;
      end else if (st_r.width != {CNT_W{1'b1}}) begin
         st_nxt.width = st_r.width + 1'b1;
      end
      if (fwd_fall && st_r.width < CNT_W'(PULSE_MIN_CYC)) begin
         err_set[ERR_PULSE_BIT] = 1'b1;
      end

      st_nxt.step_ev  = ev;
      st_nxt.drv_en   = enabled;
      st_nxt.div      = dec_div;
      st_nxt.fallback = dec_fallback;
      if (ev) begin
         st_nxt.step_dir = ev_dir;
         if (ev_dir) begin
            st_nxt.pos = st_r.pos - 1'b1;
         end else begin
            st_nxt.pos = st_r.pos + 1'b1;
         end
      end

      // APB: answer prepared in setup, presented in one access cycle
      setup     = i_psel & ~i_penable;
      commit_wr = i_psel & i_penable & st_r.pready & i_pwrite &
                  ~st_r.pslverr;
      hit       = 1'b1;
      rd_val    = '0;
      case (i_paddr)
         ADDR_CTRL: begin
            rd_val[CTRL_W-1:0] = st_r.ctrl;
         end
         ADDR_STATUS: begin
            rd_val[STAT_EN_BIT]               = st_r.drv_en;
            rd_val[STAT_DIR_BIT]              = st_r.step_dir;
            rd_val[STAT_FB_BIT]               = st_r.fallback;
            rd_val[STAT_DIV_LSB +: DIV_W]     = st_r.div;
         end
         ADDR_POS: begin
            rd_val[POS_W-1:0] = st_r.pos;
         end
         ADDR_ERR: begin
            rd_val[ERR_W-1:0] = st_r.err;
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      st_nxt.pready  = setup;
      st_nxt.pslverr = setup & ~hit;
      st_nxt.prdata  = (setup && !i_pwrite) ? rd_val : '0;

      st_nxt.err = st_r.err;
      if (commit_wr) begin
         case (i_paddr)
            ADDR_CTRL: st_nxt.ctrl = i_pwdata[CTRL_W-1:0];
            ADDR_POS:  st_nxt.pos  = i_pwdata[POS_W-1:0];
            ADDR_ERR:  st_nxt.err  = st_r.err & ~i_pwdata[ERR_W-1:0];
            default:   st_nxt.ctrl = st_r.ctrl;
         endcase
      end
      // Hardware set wins over a same-cycle clear
      st_nxt.err = st_nxt.err | err_set;
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_r          <= '0;
         st_r.ctrl     <= CTRL_RESET;
         st_r.err      <= ERR_RESET;
         st_r.drv_en   <= 1'b1;
         st_r.div      <= DIV_BIN_BASE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_prdata       = st_r.prdata;
   assign o_pready       = st_r.pready;
   assign o_pslverr      = st_r.pslverr;
   assign o_step_event   = st_r.step_ev;
   assign o_step_dir     = st_r.step_dir;
   assign o_drive_enable = st_r.drv_en;
   assign o_res_div      = st_r.div;
   assign o_res_fallback = st_r.fallback;

endmodule
`default_nettype wire

// *** dv/sdid_properties.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdid_checker
   import sdid_pkg::*;
(
   input wire logic              i_mclk,
   input wire logic              i_srst,
   input wire logic              i_psel,
   input wire logic              i_penable,
   input wire logic              i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0]       i_pwdata,
   input wire logic              o_pready,
   input wire logic              o_pslverr,
   input wire logic              i_step_pulse_input,
   input wire logic              i_rotation_sense_input,
   input wire logic              i_output_gate_input,
   input wire logic              o_step_event,
   input wire logic              o_step_dir,
   input wire logic              o_drive_enable,
   input wire logic [DIV_W-1:0]  o_res_div,
   input wire logic              o_res_fallback
);
   localparam logic [8:0] DTAB [8] = '{DIV_DEC_0, DIV_DEC_1, DIV_DEC_2,
      DIV_DEC_3, DIV_DEC_4, DIV_DEC_5, DIV_FALLBACK, DIV_FALLBACK};
   logic [7:0] ctrl;
   logic       pd;
   logic       dual;
   logic       pol;

   // Shadow of the control register, taken at the committing APB edge
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ctrl <= 8'h00;
      end else if (i_psel && i_penable && o_pready && i_pwrite &&
                   i_paddr == ADDR_CTRL) begin
         ctrl <= i_pwdata[7:0];
      end
   end
   assign pd   = o_drive_enable && !ctrl[0];
   assign dual = o_drive_enable && ctrl[0];
   assign pol  = ctrl[1];

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   rst_values_a: assert property (
      $fell(i_srst) |-> o_drive_enable && o_res_div == 9'h002 && !o_step_dir)
      else $error("outputs not at reset values");
   div_decode_a: assert property (
      o_res_div == $past(ctrl[4] ? DTAB[ctrl[7:5]] : 9'h002 << ctrl[7:5]))
      else $error("resolution divisor wrong");
   fallback_flag_a: assert property (
      o_res_fallback == $past(ctrl[4] && ctrl[7:6] == 2'b11))
      else $error("fallback flag wrong");
   // Shadow still holds the old control value on the first edge after reset
   gate_enable_a: assert property (
      o_drive_enable == ($past(i_srst) || !$past(ctrl[3]) ||
      ($past(ctrl[2]) ^ $past(i_output_gate_input, 3))))
      else $error("drive enable wrong");
   pd_step_a: assert property (
      pd && (pol ? $fell(i_step_pulse_input) : $rose(i_step_pulse_input))
      |-> ##[3:5] o_step_event)
      else $error("missing step in pulse mode");
   dir_level_a: assert property (
      o_step_event && !ctrl[0] |-> o_step_dir == i_rotation_sense_input)
      else $error("step direction not the level");
   dual_fwd_a: assert property (
      dual && (pol ? $fell(i_step_pulse_input) : $rose(i_step_pulse_input))
      |-> ##[3:5] o_step_event && !o_step_dir)
      else $error("missing forward step");
   dual_rev_a: assert property (
      dual && (pol ? $fell(i_rotation_sense_input) :
      $rose(i_rotation_sense_input)) |-> ##[3:5] o_step_event && o_step_dir)
      else $error("missing reverse step");
   one_event_a: assert property (
      o_step_event |=> !o_step_event)
      else $error("step event longer than a cycle");

   cover property (o_step_event && o_step_dir);
   cover property (o_res_fallback);
   cover property (o_pready && o_pslverr);
   cover property (!o_drive_enable);
endmodule

bind sdid_top sdid_checker i_sdid_checker (.*);

`default_nettype wire

// *** dv/sdid_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdid_ctrl_model
   import sdid_pkg::*;
(
   input  wire logic i_mclk,
   output logic      o_step,
   output logic      o_dir
);
   initial begin
      o_step = 1'b0;
      o_dir  = 1'b0;
   end

   // Park both lines inactive; only while the drive is off, or it steps
   task automatic idle(input logic pol);
      @(posedge i_mclk);
      o_step <= pol;
      o_dir  <= pol;
   endtask

   // One step; dual mode puts reverse steps on the direction line
   task automatic step(input logic dual, input logic pol, input logic rev);
      @(posedge i_mclk);
      if (!dual) begin
         o_dir <= rev;
         repeat (DIR_SETUP_CYC + 1) @(posedge i_mclk);
      end
      if (dual && rev) o_dir <= ~pol;
      else o_step <= ~pol;
      repeat (PULSE_MIN_CYC + 2) @(posedge i_mclk);
      if (dual && rev) o_dir <= pol;
      else o_step <= pol;
      repeat (PULSE_MIN_CYC + 2) @(posedge i_mclk);
   endtask

   // Deliberately short step pulse, breaking the width rule on purpose
   task automatic pulse(input logic pol, input int len);
      @(posedge i_mclk);
      o_step <= ~pol;
      repeat (len) @(posedge i_mclk);
      o_step <= pol;
      repeat (PULSE_MIN_CYC + 2) @(posedge i_mclk);
   endtask
endmodule

`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench
   import sdid_pkg::*;
;
   typedef struct packed {
      logic [7:0] ctrl;
      logic       gate;
      logic       en;
      logic [8:0] div;
   } sdid_row_s;

   logic        i_mclk = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_psel = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite = 1'b0;
   logic        i_output_gate_input = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic [31:0] o_prdata, rd;
   logic [8:0]  o_res_div;
   logic        o_pready, o_pslverr, o_step_event, o_step_dir, err, fb;
   logic        o_drive_enable, o_res_fallback;
   logic        i_step_pulse_input, i_rotation_sense_input;
   int          bad_count = 0;
   int          comparisons = 0;
   sdid_row_s   rows [20] = '{
      '{8'h00, 1'b0, 1'b1, 9'h002}, '{8'h10, 1'b0, 1'b1, 9'h005},
      '{8'h20, 1'b0, 1'b1, 9'h004}, '{8'h30, 1'b0, 1'b1, 9'h00A},
      '{8'h40, 1'b0, 1'b1, 9'h008}, '{8'h50, 1'b0, 1'b1, 9'h019},
      '{8'h60, 1'b0, 1'b1, 9'h010}, '{8'h70, 1'b0, 1'b1, 9'h032},
      '{8'h80, 1'b0, 1'b1, 9'h020}, '{8'h90, 1'b0, 1'b1, 9'h07D},
      '{8'hA0, 1'b0, 1'b1, 9'h040}, '{8'hB0, 1'b0, 1'b1, 9'h0FA},
      '{8'hC0, 1'b0, 1'b1, 9'h080}, '{8'hD0, 1'b0, 1'b1, 9'h100},
      '{8'hE0, 1'b0, 1'b1, 9'h100}, '{8'hF0, 1'b0, 1'b1, 9'h100},
      '{8'h08, 1'b1, 1'b1, 9'h002}, '{8'h0C, 1'b0, 1'b1, 9'h002},
      '{8'h0C, 1'b1, 1'b0, 9'h002}, '{8'h08, 1'b0, 1'b0, 9'h002}};

   sdid_top i_sdid_top (.*);
   sdid_ctrl_model i_sdid_ctrl_model (
      .i_mclk (i_mclk),
      .o_step (i_step_pulse_input),
      .o_dir  (i_rotation_sense_input)
   );

   always #50 i_mclk = ~i_mclk;

   task automatic chk(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      if (bad_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Idle cycle first, so a release never meets the next setup
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n = 0;
      @(posedge i_mclk);
      i_psel   <= 1'b1;
      i_pwrite <= wr;
      i_paddr  <= a;
      i_pwdata <= wd;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      err = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
      if (o_pready !== 1'b1) begin
         bad_count++;
         final_report();
      end
   endtask

   initial begin
      repeat (4) @(posedge i_mclk);
      i_srst <= 1'b0;
      foreach (rows[i]) begin
         i_output_gate_input <= rows[i].gate;
         apb(1'b1, ADDR_CTRL, {24'h0, rows[i].ctrl});
         repeat (4) @(posedge i_mclk);
         fb = rows[i].ctrl[4] && rows[i].div == 9'h100;
         chk("enable", o_drive_enable, rows[i].en);
         chk("divisor", o_res_div, rows[i].div);
         chk("fallback", o_res_fallback, fb);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("status", rd, {rows[i].div, 5'h00, fb, 1'b0, rows[i].en});
      end
      i_srst <= 1'b1;
      @(posedge i_mclk);
      i_srst <= 1'b0;
      @(posedge i_mclk);
      chk("reset enable", o_drive_enable, 1'b1);
      chk("reset divisor", o_res_div, 9'h002);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("reset control", rd, 32'h0);
      repeat (3) i_sdid_ctrl_model.step(1'b0, 1'b0, 1'b0);
      repeat (2) i_sdid_ctrl_model.step(1'b0, 1'b0, 1'b1);
      chk("reverse dir", o_step_dir, 1'b1);
      apb(1'b0, ADDR_POS, 32'h0);
      chk("position", rd, 32'h1);
      apb(1'b0, ADDR_ERR, 32'h0);
      chk("clean errors", rd, 32'h0);
      // Gated with the gate low: the drive is off and must not step
      apb(1'b1, ADDR_CTRL, 32'h0A);
      i_sdid_ctrl_model.idle(1'b1);
      i_sdid_ctrl_model.step(1'b0, 1'b1, 1'b0);
      i_output_gate_input <= 1'b1;
      i_sdid_ctrl_model.step(1'b0, 1'b1, 1'b0);
      apb(1'b0, ADDR_POS, 32'h0);
      chk("falling position", rd, 32'h2);
      i_output_gate_input <= 1'b0;
      i_sdid_ctrl_model.idle(1'b1);
      apb(1'b1, ADDR_CTRL, 32'h0B);
      i_output_gate_input <= 1'b1;
      repeat (4) @(posedge i_mclk);
      i_sdid_ctrl_model.step(1'b1, 1'b1, 1'b0);
      repeat (2) i_sdid_ctrl_model.step(1'b1, 1'b1, 1'b1);
      chk("dual dir", o_step_dir, 1'b1);
      apb(1'b0, ADDR_POS, 32'h0);
      chk("dual position", rd, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped error", err, 1'b1);
      // Short pulse soon after a direction change sets both error bits
      apb(1'b1, ADDR_CTRL, 32'h02);
      apb(1'b1, ADDR_ERR, 32'h3);
      i_sdid_ctrl_model.pulse(1'b1, 3);
      apb(1'b0, ADDR_ERR, 32'h0);
      chk("short pulse errors", rd, 32'h3);
      final_report();
   end
endmodule

`default_nettype wire
